/* File: common/fdpp_pkg.sv */
/*
  Shared constants and types for the flexible-disk parameter page and its drive sequencer:
  page byte offsets, field positions, reset values, defaults, timing bases and state codes.
  Assumes a single 125 MHz clock and a byte-wide page access port driven by the command layer.
*/
package fdpp_pkg;

  // Timing base
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1;
  localparam int CYC_PER_US = TICK_US * CLK_MHZ;
  localparam int US_PER_100US = 100;
  localparam int HUNDRED_US_PER_MS = 10;
  localparam int MS_PER_100MS = 100;

  // Page byte offsets
  localparam logic [4:0] OFS_PAGE_HEADER = 5'h00;
  localparam logic [4:0] OFS_PAGE_LENGTH = 5'h01;
  localparam logic [4:0] OFS_TRANSFER_RATE = 5'h02;
  localparam logic [4:0] OFS_HEAD_COUNT = 5'h04;
  localparam logic [4:0] OFS_SECTORS_PER_TRACK = 5'h05;
  localparam logic [4:0] OFS_BYTES_PER_SECTOR = 5'h06;
  localparam logic [4:0] OFS_CYLINDER_COUNT = 5'h08;
  localparam logic [4:0] OFS_PRECOMP_START = 5'h0A;
  localparam logic [4:0] OFS_LOW_CURRENT_START = 5'h0C;
  localparam logic [4:0] OFS_STEP_INTERVAL = 5'h0E;
  localparam logic [4:0] OFS_STEP_PULSE_LEN = 5'h10;
  localparam logic [4:0] OFS_SETTLE_TIME = 5'h11;
  localparam logic [4:0] OFS_SPINUP_WAIT = 5'h13;
  localparam logic [4:0] OFS_SPINDOWN_WAIT = 5'h14;
  localparam logic [4:0] OFS_DRIVE_OPTION_FLAGS = 5'h15;
  localparam logic [4:0] OFS_EXTRA_STEP_CONFIG = 5'h16;
  localparam logic [4:0] OFS_WRITE_COMP_AMOUNT = 5'h17;
  localparam logic [4:0] OFS_LOAD_TIME = 5'h18;
  localparam logic [4:0] OFS_UNLOAD_TIME = 5'h19;
  localparam logic [4:0] OFS_LINE_SELECT_A = 5'h1A;
  localparam logic [4:0] OFS_LINE_SELECT_B = 5'h1B;
  localparam logic [4:0] OFS_SPIN_SPEED = 5'h1C;

  // Field positions
  localparam int SAVE_CAPABLE_BIT = 7;
  localparam int TRUE_READY_BIT = 7;
  localparam int SECTOR_BASE_BIT = 6;
  localparam int MOTOR_HOLD_BIT = 5;
  localparam int SEL_A_POL_BIT = 7;
  localparam int SEL_A_FUNC_LSB = 4;
  localparam int SEL_B_POL_BIT = 7;
  localparam int SEL_B_FUNC_LSB = 4;
  localparam int SEL_C_POL_BIT = 3;
  localparam int SEL_C_FUNC_LSB = 0;

  // Line function codes
  localparam logic [2:0] LINE_OPEN = 3'h0;
  localparam logic [2:0] LINE_A_READY = 3'h1;
  localparam logic [2:0] LINE_A_DISK_CHANGED = 3'h2;
  localparam logic [2:0] LINE_B_IN_USE = 3'h1;
  localparam logic [2:0] LINE_B_EJECT = 3'h2;
  localparam logic [2:0] LINE_B_HEAD_LOAD = 3'h3;
  localparam logic [2:0] LINE_C_DC_RESET = 3'h1;

  // Fixed page content
  localparam logic SAVE_CAPABLE = 1'b0;
  localparam logic [5:0] PAGE_CODE = 6'h05;
  localparam logic [7:0] PAGE_LEN = 8'h1E;
  localparam logic [15:0] SPIN_RPM = 16'h012C;
  localparam logic [7:0] MOTOR_NEVER_OFF = 8'hFF;

  // Reset values of writable fields
  localparam logic [15:0] RST_RATE = 16'h01F4;
  localparam logic [7:0] RST_HEADS = 8'h02;
  localparam logic [7:0] RST_SPT = 8'h12;
  localparam logic [15:0] RST_BPS = 16'h0200;
  localparam logic [15:0] RST_CYLS = 16'h0050;
  localparam logic [7:0] RST_CLEARED = 8'h00;

  // Substitutes used when a timing or write-compensation field is zero
  localparam logic [15:0] DEF_STEP_100US = 16'h001E;
  localparam logic [7:0] DEF_PULSE_US = 8'h04;
  localparam logic [15:0] DEF_SETTLE_100US = 16'h0096;
  localparam logic [7:0] DEF_WRITE_COMP = 8'h08;
  localparam logic [7:0] DEF_LOAD_MS = 8'h0F;
  localparam logic [7:0] DEF_UNLOAD_MS = 8'h0F;

  // Byte 0 sits in the low bits; precompensation and low-current starts equal the count
  localparam logic [255:0] PAGE_RESET = {
    8'h00, 8'h00, SPIN_RPM[7:0], SPIN_RPM[15:8],
    {6{RST_CLEARED}}, {8{RST_CLEARED}},
    RST_CYLS[7:0], RST_CYLS[15:8], RST_CYLS[7:0], RST_CYLS[15:8],
    RST_CYLS[7:0], RST_CYLS[15:8], RST_BPS[7:0], RST_BPS[15:8],
    RST_SPT, RST_HEADS, RST_RATE[7:0], RST_RATE[15:8],
    PAGE_LEN, {SAVE_CAPABLE, 1'b0, PAGE_CODE}};

  localparam logic [255:0] PAGE_WMASK = {
    {4{8'h00}}, {5{8'hFF}}, 8'h0F, 8'hE0, {19{8'hFF}}, 8'h00, 8'h00};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } fdpp_page_req_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_SPIN = 8'h02,
    ST_PULSE = 8'h04,
    ST_GAP = 8'h08,
    ST_SETTLE = 8'h10,
    ST_LOAD = 8'h20,
    ST_ACTIVE = 8'h40,
    ST_UNLOAD = 8'h80
  } fdpp_state_t;

  typedef enum logic [1:0] {
    U_US = 2'h0,
    U_100US = 2'h1,
    U_MS = 2'h2,
    U_100MS = 2'h3
  } fdpp_unit_t;

endpackage

/* File: rtl/fdpp_tick_gen.sv */
/*
  Chained prescaler producing one-cycle ticks every microsecond, 100 us, millisecond
  and 100 ms. Assumes a free-running clock; CLK_PER_US may be shrunk in simulation.
*/
`timescale 1ns/100ps
module fdpp_tick_gen #(
  parameter int unsigned CLK_PER_US = fdpp_pkg::CYC_PER_US
) (
  input wire logic clk_i,
  input wire logic srst_i,
  output logic [3:0] ticks_o
);
  import fdpp_pkg::*;

  localparam int unsigned DIV [4] = '{CLK_PER_US, US_PER_100US, HUNDRED_US_PER_MS,
    MS_PER_100MS};

  logic [4:0] stage_in;

  assign stage_in[0] = 1'b1;
  assign ticks_o = stage_in[4:1];

  for (genvar i = 0; i < 4; i++)
  begin : g_stage
    logic [15:0] cnt_q;
    logic wrap;

    assign wrap = stage_in[i] && (cnt_q == 16'(DIV[i] - 1));
    assign stage_in[i + 1] = wrap;

    always_ff @(posedge clk_i)
    begin
      if (srst_i)
        cnt_q <= 16'h0000;
      else if (wrap)
        cnt_q <= 16'h0000;
      else if (stage_in[i])
        cnt_q <= cnt_q + 16'h0001;
    end
  end

endmodule

/* File: rtl/fdpp_page_ctrl.sv */
/*
  Flexible-disk parameter page and drive sequencer: holds the page written by mode select,
  returns it for mode sense, and runs motor, stepping, settle, head load and unload timing.
  Assumes the command layer drives page_req_i one byte at a time and requests one medium
  access at a time, ending it with access_done_i.
*/
//
// Summary of operation
// - Save-capable bit read-only, reported in sense data
// - Transfer rate field is kbit/s
// - Precompensation from start cylinder; off when equal count
// - Reduced current from start cylinder; off when equal
// - Step spacing in 100 us, zero means default
// - Step pulse width in us, zero means default
// - Settle time in 100 us, zero means default
// - Without ready line, wait spin-up before access
// - With ready line, wait for ready, else abort
// - Motor released after idle delay; FFh never
// - True-ready flag selects spin-up behaviour
// - Sector numbering starts at one or zero
// - Motor-hold flag keeps motor line released
// - Extra step pulses per cylinder added
// - Write compensation from precompensation cylinder; zero means default
// - Head load time in ms, zero means default
// - Head unload time in ms, zero means default
// - First line: polarity, open/ready/disk changed
// - Second line: open/in use/eject/head load
// - Third line: open or disk-change reset
// - Rotation speed reported, mode select ignored
`timescale 1ns/100ps
module fdpp_page_ctrl #(
  parameter int unsigned CLK_PER_US = fdpp_pkg::CYC_PER_US
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input fdpp_pkg::fdpp_page_req_t page_req_i,
  output logic [7:0] page_rdata_o,
  output logic page_rvalid_o,
  input wire logic access_req_i,
  input wire logic [15:0] target_cyl_i,
  input wire logic access_done_i,
  input wire logic start_unit_i,
  input wire logic stop_unit_i,
  input wire logic eject_req_i,
  input wire logic dc_reset_req_i,
  input wire logic line_a_i,
  output logic access_grant_o,
  output logic access_abort_o,
  output logic busy_o,
  output logic motor_on_o,
  output logic step_o,
  output logic step_dir_o,
  output logic [15:0] cur_cyl_o,
  output logic precomp_en_o,
  output logic reduce_current_o,
  output logic [7:0] write_comp_o,
  output logic [15:0] rate_kbps_o,
  output logic [7:0] first_sector_o,
  output logic drive_ready_o,
  output logic disk_changed_o,
  output logic line_b_o,
  output logic line_b_oe_o,
  output logic line_c_o,
  output logic line_c_oe_o
);
  import fdpp_pkg::*;

  logic [7:0] page_q [32];
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [3:0] ticks;
  fdpp_state_t state_q;
  fdpp_unit_t unit_q;
  logic [15:0] dly_q;
  logic [20:0] steps_q;
  logic [15:0] target_q;
  logic [15:0] cur_cyl_q;
  logic dir_q;
  logic grant_q;
  logic abort_q;
  logic motor_q;
  logic unit_hold_q;
  logic [7:0] idle_cnt_q;
  logic warm_q;

  fdpp_tick_gen #(
    .CLK_PER_US(CLK_PER_US)
  ) u_ticks (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ticks_o(ticks)
  );

  // Page storage: masked bits keep their value, so read-only fields ignore mode select
  for (genvar b = 0; b < 32; b++)
  begin : g_page
    localparam logic [7:0] WMASK = PAGE_WMASK[8 * b +: 8];

    always_ff @(posedge clk_i)
    begin
      if (srst_i)
        page_q[b] <= PAGE_RESET[8 * b +: 8];
      else if (page_req_i.wr && (page_req_i.addr == 5'(b)))
        page_q[b] <= (page_q[b] & ~WMASK) | (page_req_i.wdata & WMASK);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= page_req_i.rd;
      if (page_req_i.rd)
        rdata_q <= page_q[page_req_i.addr];
    end
  end

  assign page_rdata_o = rdata_q;
  assign page_rvalid_o = rvalid_q;

  // Field views
  logic [15:0] f_rate;
  logic [15:0] f_cyls;
  logic [15:0] f_wp;
  logic [15:0] f_rwc;
  logic [15:0] f_step;
  logic [7:0] f_pulse;
  logic [15:0] f_settle;
  logic [7:0] f_spinup;
  logic [7:0] f_spindown;
  logic [7:0] f_opts;
  logic [3:0] f_extra;
  logic [7:0] f_wcomp;
  logic [7:0] f_load;
  logic [7:0] f_unload;
  logic [7:0] f_sel_a;
  logic [7:0] f_sel_b;

  assign f_rate = {page_q[OFS_TRANSFER_RATE], page_q[OFS_TRANSFER_RATE + 5'h01]};
  assign f_cyls = {page_q[OFS_CYLINDER_COUNT], page_q[OFS_CYLINDER_COUNT + 5'h01]};
  assign f_wp = {page_q[OFS_PRECOMP_START], page_q[OFS_PRECOMP_START + 5'h01]};
  assign f_rwc = {page_q[OFS_LOW_CURRENT_START], page_q[OFS_LOW_CURRENT_START + 5'h01]};
  assign f_step = {page_q[OFS_STEP_INTERVAL], page_q[OFS_STEP_INTERVAL + 5'h01]};
  assign f_pulse = page_q[OFS_STEP_PULSE_LEN];
  assign f_settle = {page_q[OFS_SETTLE_TIME], page_q[OFS_SETTLE_TIME + 5'h01]};
  assign f_spinup = page_q[OFS_SPINUP_WAIT];
  assign f_spindown = page_q[OFS_SPINDOWN_WAIT];
  assign f_opts = page_q[OFS_DRIVE_OPTION_FLAGS];
  assign f_extra = page_q[OFS_EXTRA_STEP_CONFIG][3:0];
  assign f_wcomp = page_q[OFS_WRITE_COMP_AMOUNT];
  assign f_load = page_q[OFS_LOAD_TIME];
  assign f_unload = page_q[OFS_UNLOAD_TIME];
  assign f_sel_a = page_q[OFS_LINE_SELECT_A];
  assign f_sel_b = page_q[OFS_LINE_SELECT_B];

  logic true_ready_present;
  logic sector_base_one;
  logic motor_line_hold_released;

  assign true_ready_present = f_opts[TRUE_READY_BIT];
  assign sector_base_one = f_opts[SECTOR_BASE_BIT];
  assign motor_line_hold_released = f_opts[MOTOR_HOLD_BIT];

  // Zero fields fall back to the built-in defaults
  logic [15:0] step_eff;
  logic [15:0] pulse_eff;
  logic [15:0] settle_eff;
  logic [15:0] load_eff;
  logic [15:0] unload_eff;

  assign step_eff = (f_step == 16'h0000) ? DEF_STEP_100US : f_step;
  assign pulse_eff = {8'h00, (f_pulse == 8'h00) ? DEF_PULSE_US : f_pulse};
  assign settle_eff = (f_settle == 16'h0000) ? DEF_SETTLE_100US : f_settle;
  assign load_eff = {8'h00, (f_load == 8'h00) ? DEF_LOAD_MS : f_load};
  assign unload_eff = {8'h00, (f_unload == 8'h00) ? DEF_UNLOAD_MS : f_unload};

  // Line A input decode; polarity bit gives the active level
  logic [2:0] func_a;
  logic line_a_active;
  logic drive_ready;

  assign func_a = f_sel_a[SEL_A_FUNC_LSB +: 3];
  assign line_a_active = (line_a_i == f_sel_a[SEL_A_POL_BIT]);
  assign drive_ready = (func_a == LINE_A_READY) && line_a_active;

  // Delay timer: loaded with N, done on the tick seen at zero, so N+1 ticks elapse.
  // The first tick may come early, hence the extra one keeps every delay at or above N.
  logic unit_tick;
  logic dly_done;

  always_comb
  begin
    case (unit_q)
      U_US: unit_tick = ticks[0];
      U_100US: unit_tick = ticks[1];
      U_MS: unit_tick = ticks[2];
      default: unit_tick = ticks[3];
    endcase
  end

  assign dly_done = unit_tick && (dly_q == 16'h0000);

  // Seek length for the latched target, widened by the extra pulses per cylinder
  logic [15:0] seek_dist;
  logic [20:0] seek_steps;

  assign seek_dist = (target_q >= cur_cyl_q) ? (target_q - cur_cyl_q) : (cur_cyl_q - target_q);
  assign seek_steps = 21'(seek_dist) * 21'({1'b0, f_extra} + 5'h01);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_q <= ST_IDLE;
      unit_q <= U_US;
      dly_q <= 16'h0000;
      steps_q <= 21'h000000;
      target_q <= 16'h0000;
      cur_cyl_q <= 16'h0000;
      dir_q <= 1'b0;
      grant_q <= 1'b0;
      abort_q <= 1'b0;
      warm_q <= 1'b0;
    end
    else
    begin
      grant_q <= 1'b0;
      abort_q <= 1'b0;
      if (unit_tick && (dly_q != 16'h0000))
        dly_q <= dly_q - 16'h0001;
      case (state_q)
        ST_IDLE:
        begin
          if (access_req_i)
          begin
            target_q <= target_cyl_i;
            dir_q <= (target_cyl_i >= cur_cyl_q);
            warm_q <= motor_q;
            state_q <= ST_SPIN;
            unit_q <= U_100MS;
            // A running motor needs no spin-up wait
            dly_q <= motor_q ? 16'h0000 : {8'h00, f_spinup};
          end
        end
        ST_SPIN:
        begin
          // A motor started by this request must still see ready or the full delay
          if (warm_q || (true_ready_present && drive_ready)
              || (!true_ready_present && dly_done))
          begin
            steps_q <= seek_steps;
            if (seek_steps == 21'h000000)
            begin
              state_q <= ST_LOAD;
              unit_q <= U_MS;
              dly_q <= load_eff;
            end
            else
            begin
              state_q <= ST_PULSE;
              unit_q <= U_US;
              dly_q <= pulse_eff;
            end
          end
          else if (true_ready_present && dly_done)
          begin
            abort_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_PULSE:
        begin
          if (dly_done)
          begin
            steps_q <= steps_q - 21'h000001;
            state_q <= ST_GAP;
            unit_q <= U_100US;
            dly_q <= step_eff;
          end
        end
        ST_GAP:
        begin
          if (dly_done && steps_q == 21'h000000)
          begin
            cur_cyl_q <= target_q;
            state_q <= ST_SETTLE;
            dly_q <= settle_eff;
          end
          else if (dly_done)
          begin
            state_q <= ST_PULSE;
            unit_q <= U_US;
            dly_q <= pulse_eff;
          end
        end
        ST_SETTLE:
        begin
          if (dly_done)
          begin
            state_q <= ST_LOAD;
            unit_q <= U_MS;
            dly_q <= load_eff;
          end
        end
        ST_LOAD:
        begin
          if (dly_done)
          begin
            grant_q <= 1'b1;
            state_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE:
        begin
          if (access_done_i)
          begin
            state_q <= ST_UNLOAD;
            unit_q <= U_MS;
            dly_q <= unload_eff;
          end
        end
        ST_UNLOAD:
        begin
          if (dly_done)
            state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Motor: start/stop commands act directly and the idle timer never overrides a start
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      motor_q <= 1'b0;
      unit_hold_q <= 1'b0;
      idle_cnt_q <= 8'h00;
    end
    else if (stop_unit_i)
    begin
      motor_q <= 1'b0;
      unit_hold_q <= 1'b0;
      idle_cnt_q <= 8'h00;
    end
    else if (start_unit_i || (state_q == ST_IDLE && access_req_i))
    begin
      motor_q <= 1'b1;
      unit_hold_q <= unit_hold_q || start_unit_i;
      idle_cnt_q <= 8'h00;
    end
    else if (state_q != ST_IDLE || unit_hold_q || !motor_q)
      idle_cnt_q <= 8'h00;
    else if (ticks[3])
    begin
      if (idle_cnt_q == f_spindown && f_spindown != MOTOR_NEVER_OFF)
        motor_q <= 1'b0;
      else if (idle_cnt_q != MOTOR_NEVER_OFF)
        idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end

  // Registered drive-facing outputs
  logic [2:0] func_b;
  logic [2:0] func_c;
  logic b_assert;

  assign func_b = f_sel_b[SEL_B_FUNC_LSB +: 3];
  assign func_c = f_sel_b[SEL_C_FUNC_LSB +: 3];

  always_comb
  begin
    case (func_b)
      LINE_B_IN_USE: b_assert = (state_q != ST_IDLE);
      LINE_B_EJECT: b_assert = eject_req_i;
      LINE_B_HEAD_LOAD: b_assert = (state_q == ST_LOAD) || (state_q == ST_ACTIVE);
      default: b_assert = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      motor_on_o <= 1'b0;
      step_o <= 1'b0;
      precomp_en_o <= 1'b0;
      reduce_current_o <= 1'b0;
      write_comp_o <= 8'h00;
      rate_kbps_o <= 16'h0000;
      first_sector_o <= 8'h00;
      drive_ready_o <= 1'b0;
      disk_changed_o <= 1'b0;
      line_b_o <= 1'b0;
      line_b_oe_o <= 1'b0;
      line_c_o <= 1'b0;
      line_c_oe_o <= 1'b0;
    end
    else
    begin
      motor_on_o <= motor_q && !motor_line_hold_released;
      step_o <= (state_q == ST_PULSE);
      precomp_en_o <= (f_wp != f_cyls) && (cur_cyl_q >= f_wp);
      reduce_current_o <= (f_rwc != f_cyls) && (cur_cyl_q >= f_rwc);
      if ((f_wp != f_cyls) && (cur_cyl_q >= f_wp))
        write_comp_o <= (f_wcomp == 8'h00) ? DEF_WRITE_COMP : f_wcomp;
      else
        write_comp_o <= 8'h00;
      rate_kbps_o <= f_rate;
      first_sector_o <= {7'h00, sector_base_one};
      drive_ready_o <= drive_ready;
      disk_changed_o <= (func_a == LINE_A_DISK_CHANGED) && line_a_active;
      line_b_oe_o <= (func_b != LINE_OPEN) && (func_b <= LINE_B_HEAD_LOAD);
      line_b_o <= b_assert ? f_sel_b[SEL_B_POL_BIT] : !f_sel_b[SEL_B_POL_BIT];
      line_c_oe_o <= (func_c == LINE_C_DC_RESET);
      line_c_o <= dc_reset_req_i ? f_sel_b[SEL_C_POL_BIT] : !f_sel_b[SEL_C_POL_BIT];
    end
  end

  assign access_grant_o = grant_q;
  assign access_abort_o = abort_q;
  assign busy_o = (state_q != ST_IDLE);
  assign step_dir_o = dir_q;
  assign cur_cyl_o = cur_cyl_q;

endmodule

/* File: dv/fdpp_drive_model.sv */
/*
  Drive model: tracks head position from step pulses, raises ready after spin-up.
  Assumes registered motor, step and direction lines from the controller.
*/
`timescale 1ns/100ps
module fdpp_drive_model (
  input wire logic clk_i,
  input wire logic motor_on_i,
  input wire logic step_i,
  input wire logic step_dir_i,
  input wire logic rdy_en_i,
  output logic ready_o,
  output int pos_o
);
  int spin_q = 0;
  logic step_q = 1'b0;
  initial pos_o = 0;
  always @(posedge clk_i)
  begin
    step_q <= step_i;
    spin_q <= motor_on_i ? spin_q + 1 : 0;
    if (step_i && !step_q)
      pos_o <= step_dir_i ? pos_o + 1 : pos_o - 1;
  end
  // Ready comes only after the spindle has run a while, never with the motor off
  assign ready_o = rdy_en_i && (spin_q > 50);
endmodule

/* File: dv/fdpp_chk.sv */
/*
  Port checker for the page controller.
  Assumes it is bound to fdpp_page_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
module fdpp_chk
  import fdpp_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input fdpp_pkg::fdpp_page_req_t page_req_i,
  input wire logic [7:0] page_rdata_o,
  input wire logic page_rvalid_o,
  input wire logic access_grant_o,
  input wire logic access_abort_o,
  input wire logic busy_o,
  input wire logic motor_on_o,
  input wire logic step_o,
  input wire logic precomp_en_o,
  input wire logic [7:0] write_comp_o,
  input wire logic [7:0] first_sector_o
);
  logic hold_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Write-side copy of the motor-hold flag
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      hold_q <= 1'b0;
    else if (page_req_i.wr && page_req_i.addr == OFS_DRIVE_OPTION_FLAGS)
      hold_q <= page_req_i.wdata[MOTOR_HOLD_BIT];
  end
  sequence s_rd(logic [4:0] a);
    page_req_i.rd && page_req_i.addr == a;
  endsequence
  property p_hdr;
    s_rd(OFS_PAGE_HEADER) |=> page_rvalid_o && page_rdata_o == 8'h05;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header byte wrong");
  property p_spin;
    s_rd(OFS_SPIN_SPEED) |=> page_rdata_o == 8'h01;
  endproperty
  a_spin: assert property (p_spin) else $error("rotation speed wrong");
  property p_hold;
    hold_q && $past(hold_q, 2) |-> !motor_on_o;
  endproperty
  a_hold: assert property (p_hold) else $error("motor line driven while held");
  property p_pulse;
    $rose(step_o) |-> step_o [*2];
  endproperty
  a_pulse: assert property (p_pulse) else $error("step pulse too short");
  property p_step;
    step_o |-> busy_o;
  endproperty
  a_step: assert property (p_step) else $error("step outside access");
  property p_comp;
    precomp_en_o == (write_comp_o != 8'h00);
  endproperty
  a_comp: assert property (p_comp) else $error("compensation mismatch");
  property p_sector;
    first_sector_o inside {8'h00, 8'h01};
  endproperty
  a_sector: assert property (p_sector) else $error("bad first sector");
  property p_grant;
    access_grant_o |-> busy_o && $past(busy_o) && !access_abort_o;
  endproperty
  a_grant: assert property (p_grant) else $error("grant outside access");
endmodule

/* File: dv/fdpp_page_ctrl_tb.sv */
/*
  Self-checking bench: page access, stepping, geometry outputs, ready wait and drive lines.
  Assumes fdpp_pkg, the drive model and the checker are compiled first.
*/
`timescale 1ns/100ps
module fdpp_page_ctrl_tb;
  import fdpp_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  fdpp_page_req_t req = '0;
  logic acc = 1'b0, done = 1'b0, start = 1'b0, stop = 1'b0, eject = 1'b0, dcr = 1'b0;
  logic rdy_en = 1'b0;
  logic [15:0] tgt = '0;
  logic [15:0] cyl, rate;
  logic [7:0] rdata, comp, fsec;
  logic rvalid, grant, abort, busy, motor, step, dir, pre, red, dready, dchg;
  logic lb, lboe, lc, lcoe, line_a;
  logic [7:0] mdl [32];
  logic [7:0] cfg [20] = '{8'h00, 8'h50, 8'h00, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h01,
    8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h90, 8'h00};
  int fails = 0, total_checks = 0, pos, cur_m = 0;
  initial forever #4 clk_i = ~clk_i;
  // Shrunk prescaler keeps millisecond delays affordable
  fdpp_page_ctrl #(.CLK_PER_US(2)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .page_req_i(req),
    .page_rdata_o(rdata), .page_rvalid_o(rvalid), .access_req_i(acc), .target_cyl_i(tgt),
    .access_done_i(done), .start_unit_i(start), .stop_unit_i(stop), .eject_req_i(eject),
    .dc_reset_req_i(dcr), .line_a_i(line_a), .access_grant_o(grant), .access_abort_o(abort),
    .busy_o(busy), .motor_on_o(motor), .step_o(step), .step_dir_o(dir), .cur_cyl_o(cyl),
    .precomp_en_o(pre), .reduce_current_o(red), .write_comp_o(comp), .rate_kbps_o(rate),
    .first_sector_o(fsec), .drive_ready_o(dready), .disk_changed_o(dchg), .line_b_o(lb),
    .line_b_oe_o(lboe), .line_c_o(lc), .line_c_oe_o(lcoe));
  fdpp_drive_model u_drv (.clk_i(clk_i), .motor_on_i(motor), .step_i(step),
    .step_dir_i(dir), .rdy_en_i(rdy_en), .ready_o(line_a), .pos_o(pos));
  task automatic wrap_up();
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic int f16(input int a);
    return {mdl[a], mdl[a + 1]};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req = '{1'b1, 1'b0, a, d};
    // Read-only bits keep their value
    mdl[a] = (mdl[a] & ~PAGE_WMASK[a*8 +: 8]) | (d & PAGE_WMASK[a*8 +: 8]);
    @(negedge clk_i);
    req = '0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(negedge clk_i);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i);
    req = '0;
    chk("page byte", {8'h01, mdl[a]}, {7'h00, rvalid, rdata});
  endtask
  task automatic tap(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic wait_sig(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v)
    begin
      @(negedge clk_i);
      n++;
      if (n == 40000)
      begin
        fails++;
        wrap_up();
      end
    end
  endtask
  task automatic access(input int c, input int mult);
    int p0;
    logic pe;
    logic [7:0] wc;
    p0 = pos;
    tgt = 16'(c);
    tap(acc);
    wait_sig(grant, 1'b1);
    pe = c >= f16(10) && f16(10) != f16(8);
    wc = (mdl[23] != 8'h00) ? mdl[23] : DEF_WRITE_COMP;
    chk("step pulses", 16'((c - cur_m) * mult), 16'(pos - p0));
    chk("cylinder", 16'(c), cyl);
    chk("precomp", 16'(pe), 16'(pre));
    chk("low current", 16'(c >= f16(12) && f16(12) != f16(8)), 16'(red));
    chk("comp", 16'(pe ? wc : 8'h00), 16'(comp));
    chk("rate", 16'(f16(2)), rate);
    chk("first sector", 16'(mdl[21][6]), 16'(fsec));
    tap(done);
    wait_sig(busy, 1'b0);
    cur_m = c;
  endtask
  initial
  begin
    void'($urandom(63));
    for (int i = 0; i < 32; i++)
      mdl[i] = PAGE_RESET[i*8 +: 8];
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    for (int i = 0; i < 32; i++)
      rd(5'(i));
    repeat (60)
      wr(5'($urandom_range(31)), 8'($urandom));
    for (int i = 0; i < 32; i++)
      rd(5'(i));
    for (int i = 0; i < 20; i++)
      wr(5'(i + 8), cfg[i]);
    tap(start);
    repeat (4) @(negedge clk_i);
    access(20, 2);
    access(40, 2);
    wr(5'h17, 8'h05);
    wr(5'h16, 8'h00);
    access(30, 1);
    wr(5'h09, 8'h10);
    wr(5'h0B, 8'h10);
    access(20, 1);
    tap(stop);
    wr(5'h15, 8'hC0);
    rdy_en = 1'b1;
    // Spin-up would take far longer than the wait bound unless ready ends it
    access(20, 1);
    chk("ready", 16'h0001, 16'(dready));
    for (int p = 0; p < 2; p++)
      for (int e = 0; e < 2; e++)
      begin
        wr(5'h1B, {p[0], 3'b010, p[0], 3'b001});
        eject = e[0];
        dcr = e[0];
        repeat (3) @(negedge clk_i);
        chk("line b", 16'({1'b1, p[0] ~^ e[0]}), 16'({lboe, lb}));
        chk("line c", 16'({1'b1, p[0] ~^ e[0]}), 16'({lcoe, lc}));
      end
    wr(5'h15, 8'h20);
    tap(start);
    repeat (3) @(negedge clk_i);
    chk("motor", 16'h0000, 16'(motor));
    // Held motor line keeps the drive unready, so line A idles low
    wr(5'h1A, 8'h20);
    wr(5'h1B, 8'h10);
    repeat (2) @(negedge clk_i);
    chk("line a", 16'h0001, 16'({dready, dchg}));
    chk("line b in use", 16'h0006, 16'({lboe, lb, lcoe}));
    wrap_up();
  end
endmodule
bind fdpp_page_ctrl fdpp_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .page_req_i(page_req_i),
  .page_rdata_o(page_rdata_o), .page_rvalid_o(page_rvalid_o), .busy_o(busy_o),
  .access_grant_o(access_grant_o), .access_abort_o(access_abort_o), .step_o(step_o),
  .motor_on_o(motor_on_o), .precomp_en_o(precomp_en_o), .write_comp_o(write_comp_o),
  .first_sector_o(first_sector_o));
